// ### core/sse_pkg.sv
// shared constants and types of the spi shift exchange
package sse_pkg;
   localparam int SSE_BITS = 8;
   // control register fields
   localparam int CTL_WRITE_COLLISION_FLAG_BIT = 7;
   localparam int CTL_EN_BIT = 5;
   localparam int CTL_CKP_BIT = 4;
   localparam logic [7:0] CTL_RESET = 8'h00;
   // status register fields
   localparam int STAT_SMP_BIT = 7;
   localparam int STAT_CKE_BIT = 6;
   localparam logic [7:0] STAT_RESET = 8'h00;
   localparam logic [7:0] RELOAD_RESET = 8'h00;
   localparam logic [7:0] IDLE_FILL = 8'hFF;
   // mode codes in control bits 3:0
   localparam logic [3:0] MODE_DIV4 = 4'h0;
   localparam logic [3:0] MODE_DIV16 = 4'h1;
   localparam logic [3:0] MODE_DIV64 = 4'h2;
   localparam logic [3:0] MODE_TMR = 4'h3;
   localparam logic [3:0] MODE_SLV_SS = 4'h4;
   localparam logic [3:0] MODE_SLV_NOSS = 4'h5;
   localparam logic [3:0] MODE_RELOAD = 4'hA;
   // bit-rate dividers of the system clock
   localparam int DIV_FAST = 4;
   localparam int DIV_MID = 16;
   localparam int DIV_SLOW = 64;
   localparam logic [9:0] HALF_FAST = 10'(DIV_FAST / 2 - 1);
   localparam logic [9:0] HALF_MID = 10'(DIV_MID / 2 - 1);
   localparam logic [9:0] HALF_SLOW = 10'(DIV_SLOW / 2 - 1);
   localparam logic [4:0] EDGES_PER_BYTE = 5'(2 * SSE_BITS - 1);
   localparam logic [3:0] LAST_BIT = 4'(SSE_BITS - 1);
   typedef enum logic [1:0] {SSE_IDLE = 2'b01, SSE_RUN = 2'b10} sse_state_t;
endpackage

// ### core/sse_link_if.sv
// serial link between the port module and its partner
`timescale 1ns/1ps
interface sse_link_if;
   logic dev_sck;
   logic dev_sck_en;
   logic dev_sdo;
   logic dev_sdo_en;
   logic dev_ss_n;
   logic dev_ss_en;
   logic par_sck;
   logic par_sck_en;
   logic par_sdo;
   logic par_sdo_en;
   logic par_ss_n;
   logic par_ss_en;
   logic sck;
   logic ss_n;
   logic dev_sdi;
   logic par_sdi;
   // wire levels; undriven lines float to pulled levels
   assign sck = dev_sck_en ? dev_sck : (par_sck_en ? par_sck : 1'b0);
   assign ss_n = dev_ss_en ? dev_ss_n : (par_ss_en ? par_ss_n : 1'b1);
   assign dev_sdi = par_sdo_en ? par_sdo : 1'b1;
   assign par_sdi = dev_sdo_en ? dev_sdo : 1'b1;
   modport dev (output dev_sck, dev_sck_en, dev_sdo, dev_sdo_en, dev_ss_n, dev_ss_en,
                input sck, ss_n, dev_sdi);
   modport par (output par_sck, par_sck_en, par_sdo, par_sdo_en, par_ss_n, par_ss_en,
                input sck, ss_n, par_sdi);
endinterface

// ### core/sse_fifo.sv
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module sse_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [CW-1:0] cnt;
   } sse_fifo_state_t;
   sse_fifo_state_t q;
   sse_fifo_state_t d;
   logic push;
   logic pop;

   assign in_ready = (q.cnt != CW'(DEPTH));
   assign out_valid = (q.cnt != '0);
   assign out_data = q.mem[q.rp];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb
   begin
      d = q;
      if (push)
      begin
         d.mem[q.wp] = in_data;
         d.wp = (q.wp == AW'(DEPTH - 1)) ? '0 : AW'(q.wp + 1'b1);
      end
      if (pop)
      begin
         d.rp = (q.rp == AW'(DEPTH - 1)) ? '0 : AW'(q.rp + 1'b1);
      end
      if (push && !pop)
      begin
         d.cnt = CW'(q.cnt + 1'b1);
      end
      else if (pop && !push)
      begin
         d.cnt = CW'(q.cnt - 1'b1);
      end
   end

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end
endmodule

// ### core/sse_partner.sv
// far-end spi party: master or slave, fed from a byte fifo
`timescale 1ns/1ps
module sse_partner #(
   parameter logic [9:0] HALF = 10'h003,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // link
   sse_link_if.par link,
   // configuration
   input wire logic role_master,
   input wire logic clk_idle_high,
   input wire logic out_before_edge,
   // bytes to send
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic [7:0] tx_data,
   // bytes received
   output logic rx_valid,
   output logic [7:0] rx_data
);
   typedef struct packed {
      sse_pkg::sse_state_t st;
      logic [7:0] sh;
      logic [3:0] bits;
      logic [9:0] half;
      logic [4:0] edges;
      logic sck;
      logic sck_q;
      logic ss_q;
      logic sdo;
      logic ss_n;
      logic drive;
      logic sel;
      logic rx_valid;
      logic [7:0] rx_data;
   } sse_par_state_t;
   sse_par_state_t q;
   sse_par_state_t d;
   logic f_valid;
   logic f_pop;
   logic [7:0] f_data;
   logic lead;
   logic trail;
   logic smp_ev;
   logic sft_ev;

   sse_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_tx_fifo (
      .ref_clk(ref_clk),
      .reset(reset),
      .in_valid(tx_valid),
      .in_ready(tx_ready),
      .in_data(tx_data),
      .out_valid(f_valid),
      .out_ready(f_pop),
      .out_data(f_data)
   );

   always_comb
   begin
      d = q;
      f_pop = 1'b0;
      lead = 1'b0;
      trail = 1'b0;
      d.rx_valid = 1'b0;
      d.sck_q = link.sck;
      d.ss_q = link.ss_n;
      d.drive = role_master;
      if (role_master)
      begin
         if (q.st == sse_pkg::SSE_IDLE)
         begin
            d.sck = clk_idle_high;
            d.ss_n = 1'b1;
            // wait for the select to be seen high: one idle cycle between bytes
            if (f_valid && q.ss_n)
            begin
               f_pop = 1'b1;
               d.sh = f_data;
               d.sdo = f_data[7];
               d.bits = '0;
               d.half = '0;
               d.edges = '0;
               d.ss_n = 1'b0;
               d.st = sse_pkg::SSE_RUN;
            end
         end
         else if (q.half == HALF)
         begin
            d.half = '0;
            d.sck = ~q.sck;
            lead = ~q.edges[0];
            trail = q.edges[0];
            d.edges = 5'(q.edges + 1'b1);
            if (q.edges == sse_pkg::EDGES_PER_BYTE)
            begin
               d.st = sse_pkg::SSE_IDLE;
            end
         end
         else
         begin
            d.half = 10'(q.half + 1'b1);
         end
         d.sel = 1'b1;
      end
      else
      begin
         d.st = sse_pkg::SSE_IDLE;
         d.sel = !link.ss_n;
         lead = (q.sck_q == clk_idle_high) && (link.sck != clk_idle_high);
         trail = (q.sck_q != clk_idle_high) && (link.sck == clk_idle_high);
         if (link.ss_n)
         begin
            d.bits = '0;
            lead = 1'b0;
            trail = 1'b0;
         end
         if (q.ss_q && !link.ss_n)
         begin
            f_pop = f_valid;
            d.sh = f_valid ? f_data : sse_pkg::IDLE_FILL;
            d.sdo = f_valid ? f_data[7] : sse_pkg::IDLE_FILL[7];
         end
      end
      smp_ev = out_before_edge ? lead : trail;
      sft_ev = out_before_edge ? trail : lead;
      if (sft_ev)
      begin
         d.sdo = q.sh[7];
      end
      if (smp_ev)
      begin
         d.sh = {q.sh[6:0], link.par_sdi};
         d.bits = 4'(q.bits + 1'b1);
         if (q.bits == sse_pkg::LAST_BIT)
         begin
            d.bits = '0;
            d.rx_valid = 1'b1;
            d.rx_data = {q.sh[6:0], link.par_sdi};
         end
      end
   end

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         q <= '{st: sse_pkg::SSE_IDLE, ss_n: 1'b1, sck_q: 1'b0, ss_q: 1'b1, default: '0};
      end
      else
      begin
         q <= d;
      end
   end

   assign link.par_sck = q.sck;
   assign link.par_sck_en = q.drive;
   assign link.par_sdo = q.sdo;
   assign link.par_sdo_en = q.sel;
   assign link.par_ss_n = q.ss_n;
   assign link.par_ss_en = q.drive;
   assign rx_valid = q.rx_valid;
   assign rx_data = q.rx_data;
endmodule

// ### core/sse_device.sv
// spi personality of the synchronous serial port module
`timescale 1ns/1ps
module sse_device (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // link
   sse_link_if.dev link,
   // control, status and reload writes and the timer tick
   input wire logic ctl_wr,
   input wire logic [7:0] ctl_wdata,
   input wire logic stat_wr,
   input wire logic [7:0] stat_wdata,
   input wire logic reload_wr,
   input wire logic [7:0] reload_wdata,
   input wire logic timer_tick,
   // register views
   output logic [7:0] port_control_one,
   output logic [7:0] port_status_reg,
   output logic [7:0] rate_reload_value,
   // data buffer access
   input wire logic wr_en,
   input wire logic [7:0] wr_data,
   input wire logic rd_en,
   output logic [7:0] rd_data,
   output logic transfer_done_flag,
   input wire logic flag_clr
);
   typedef struct packed {
      sse_pkg::sse_state_t st;
      logic [7:0] ctl;
      logic smp;
      logic cke;
      logic [7:0] reload;
      logic [7:0] shreg;
      logic [7:0] buffer;
      logic bf;
      logic done;
      logic busy;
      logic [3:0] bits;
      logic [9:0] half;
      logic [4:0] edges;
      logic sck;
      logic sck_q;
      logic ss_q;
      logic sdo;
      logic sdo_en;
      logic ss_n;
      logic drive;
   } sse_dev_state_t;
   sse_dev_state_t q;
   sse_dev_state_t d;
   logic en;
   logic ckp;
   logic master;
   logic use_ss;
   logic selected;
   logic lead;
   logic trail;
   logic smp_ev;
   logic sft_ev;
   logic tick;
   logic [7:0] shifted;

   // ********************************************************
   // rate decode
   // ********************************************************
   function automatic logic is_master(input logic [3:0] mode);
      return (mode == sse_pkg::MODE_DIV4) || (mode == sse_pkg::MODE_DIV16) ||
             (mode == sse_pkg::MODE_DIV64) || (mode == sse_pkg::MODE_TMR) ||
             (mode == sse_pkg::MODE_RELOAD);
   endfunction

   // last count of a half bit period; timer mode never matches
   function automatic logic [9:0] half_limit(input logic [3:0] mode, input logic [7:0] add);
      case (mode)
         sse_pkg::MODE_DIV4: half_limit = sse_pkg::HALF_FAST;
         sse_pkg::MODE_DIV16: half_limit = sse_pkg::HALF_MID;
         sse_pkg::MODE_DIV64: half_limit = sse_pkg::HALF_SLOW;
         sse_pkg::MODE_RELOAD: half_limit = {1'b0, add, 1'b1};
         default: half_limit = '1;
      endcase
   endfunction

   // ********************************************************
   // next state
   // ********************************************************
   always_comb
   begin
      d = q;
      en = q.ctl[sse_pkg::CTL_EN_BIT];
      ckp = q.ctl[sse_pkg::CTL_CKP_BIT];
      master = is_master(q.ctl[3:0]);
      use_ss = (q.ctl[3:0] == sse_pkg::MODE_SLV_SS);
      selected = !use_ss || !link.ss_n;
      lead = 1'b0;
      trail = 1'b0;
      tick = 1'b0;
      shifted = {q.shreg[6:0], link.dev_sdi};
      d.sck_q = link.sck;
      d.ss_q = link.ss_n;

      if (ctl_wr)
      begin
         d.ctl = ctl_wdata;
      end
      if (stat_wr)
      begin
         d.smp = stat_wdata[sse_pkg::STAT_SMP_BIT];
         d.cke = stat_wdata[sse_pkg::STAT_CKE_BIT];
      end
      if (reload_wr)
      begin
         d.reload = reload_wdata;
      end
      if (rd_en)
      begin
         d.bf = 1'b0;
      end
      if (flag_clr)
      begin
         d.done = 1'b0;
      end

      // buffer write: taken only when idle and collision flag clear
      if (wr_en && en)
      begin
         if (q.busy || q.ctl[sse_pkg::CTL_WRITE_COLLISION_FLAG_BIT])
         begin
            d.ctl[sse_pkg::CTL_WRITE_COLLISION_FLAG_BIT] = 1'b1;
         end
         else
         begin
            d.buffer = wr_data;
            d.shreg = wr_data;
            d.sdo = wr_data[7];
            d.bits = '0;
            if (master)
            begin
               d.st = sse_pkg::SSE_RUN;
               d.half = '0;
               d.edges = '0;
               d.ss_n = 1'b0;
            end
         end
      end

      if (!en)
      begin
         d.st = sse_pkg::SSE_IDLE;
         d.bits = '0;
         d.sck = ckp;
         d.ss_n = 1'b1;
      end
      else if (master)
      begin
         if (q.st == sse_pkg::SSE_RUN)
         begin
            // timer mode toggles once per tick, giving tick rate / 2
            tick = (q.ctl[3:0] == sse_pkg::MODE_TMR) ? timer_tick :
                   (q.half == half_limit(q.ctl[3:0], q.reload));
            d.half = tick ? '0 : 10'(q.half + 1'b1);
            if (tick)
            begin
               d.sck = ~q.sck;
               lead = ~q.edges[0];
               trail = q.edges[0];
               d.edges = 5'(q.edges + 1'b1);
               // select held one more cycle so the slave still sees the last edge
               if (q.edges == sse_pkg::EDGES_PER_BYTE)
               begin
                  d.st = sse_pkg::SSE_IDLE;
               end
            end
         end
         else
         begin
            d.sck = ckp;
            if (d.st != sse_pkg::SSE_RUN)
            begin
               d.ss_n = 1'b1;
            end
         end
      end
      else
      begin
         d.st = sse_pkg::SSE_IDLE;
         d.ss_n = 1'b1;
         if (selected)
         begin
            lead = (q.sck_q == ckp) && (link.sck != ckp);
            trail = (q.sck_q != ckp) && (link.sck == ckp);
         end
         if (use_ss && link.ss_n)
         begin
            d.bits = '0;
         end
         if (use_ss && q.ss_q && !link.ss_n)
         begin
            d.sdo = q.shreg[7];
         end
      end

      // cke set: data out before the edge, so capture on leading edge
      smp_ev = q.cke ? lead : trail;
      sft_ev = q.cke ? trail : lead;
      if (sft_ev)
      begin
         d.sdo = q.shreg[7];
      end
      if (smp_ev)
      begin
         d.shreg = shifted;
         d.bits = 4'(q.bits + 1'b1);
         if (q.bits == sse_pkg::LAST_BIT)
         begin
            d.bits = '0;
            d.buffer = shifted;
            d.bf = 1'b1;
            d.done = 1'b1;
         end
      end

      d.busy = en && ((master && (d.st == sse_pkg::SSE_RUN || !d.ss_n)) ||
                      (!master && d.bits != '0));
      d.drive = en && master;
      d.sdo_en = en && (master || (!use_ss || !link.ss_n));
   end

   // ********************************************************
   // state register
   // ********************************************************
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         q <= '{st: sse_pkg::SSE_IDLE, ctl: sse_pkg::CTL_RESET,
                smp: sse_pkg::STAT_RESET[sse_pkg::STAT_SMP_BIT],
                cke: sse_pkg::STAT_RESET[sse_pkg::STAT_CKE_BIT],
                reload: sse_pkg::RELOAD_RESET, ss_n: 1'b1, ss_q: 1'b1, default: '0};
      end
      else
      begin
         q <= d;
      end
   end

   // ********************************************************
   // outputs
   // ********************************************************
   assign link.dev_sck = q.sck;
   assign link.dev_sck_en = q.drive;
   assign link.dev_sdo = q.sdo;
   assign link.dev_sdo_en = q.sdo_en;
   assign link.dev_ss_n = q.ss_n;
   assign link.dev_ss_en = q.drive;
   assign port_control_one = q.ctl;
   assign port_status_reg = {q.smp, q.cke, 4'h0, q.busy, q.bf};
   assign rate_reload_value = q.reload;
   assign rd_data = q.buffer;
   assign transfer_done_flag = q.done;
endmodule

// ### dv/sse_chk.sv
// link checker for the two joined spi ends
`timescale 1ns/1ps
module sse_chk (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // drive enables
   input wire logic dev_sck_en,
   input wire logic dev_sdo_en,
   input wire logic dev_ss_en,
   input wire logic par_sck_en,
   input wire logic par_sdo_en,
   input wire logic par_ss_en,
   // resolved wires
   input wire logic sck,
   input wire logic ss_n
);
   logic sck_q;
   logic [4:0] tog_cnt_r;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);
   // ************************************************************
   // clock edges seen inside one frame
   // ************************************************************
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         sck_q <= 1'b0;
         tog_cnt_r <= 5'h00;
      end
      else
      begin
         sck_q <= sck;
         tog_cnt_r <= ss_n ? 5'h00 : tog_cnt_r + 5'(sck != sck_q);
      end
   end
   // ************************************************************
   // properties
   // ************************************************************
   AST_ONE_CLOCK_DRIVER: assert property (!(dev_sck_en && par_sck_en))
      else $error("both ends drive the serial clock");
   AST_ONE_SELECT_DRIVER: assert property (!(dev_ss_en && par_ss_en))
      else $error("both ends drive the select line");
   // the edge landing together with the release still belongs to the frame
   AST_BYTE_SIXTEEN_EDGES: assert property ($rose(ss_n) |->
      (tog_cnt_r + 5'(sck != sck_q)) == 5'h10)
      else $error("frame closed without exactly sixteen clock edges");
   AST_MASTER_OPENS: assert property ($fell(ss_n) && dev_ss_en |-> dev_sdo_en && dev_sck_en)
      else $error("master selected without driving data and clock");
   AST_CLOCK_STILL_AT_SELECT: assert property ($fell(ss_n) |-> $stable(sck))
      else $error("clock moved in the cycle the select fell");
   AST_IDLE_GAP: assert property ($rose(ss_n) |=> ss_n)
      else $error("no idle cycle between frames");
   AST_FRAME_BOUNDED: assert property ($fell(ss_n) |-> ##[16:1000] $rose(ss_n))
      else $error("frame not closed in time");
   AST_SLAVE_QUIET: assert property (!par_ss_en && !$past(par_ss_en) && ss_n && $past(ss_n)
      |-> !par_sdo_en)
      else $error("deselected partner drives its data line");
   cover property ($fell(ss_n) && dev_ss_en);
   cover property ($fell(ss_n) && par_ss_en);
   cover property ($rose(par_sdo_en));
endmodule

// ### dv/tb_top.sv
// self-checking bench: device and partner joined over the link
`timescale 1ns/1ps
`define CHK(what, exp, got) \
   begin \
      tests_run++; \
      if ((got) !== (exp)) \
      begin \
         $display("ERROR %s expected %h seen %h", what, exp, got); \
         fails++; \
      end \
   end
module tb_top;
   typedef struct packed {logic [3:0] mode; logic ckp; logic cke; logic dev_master;
      logic [7:0] dev_byte; logic [7:0] par_byte; logic [7:0] exp_dev; logic [7:0] exp_par;} sse_row_t;
   // ************************************************************
   // ordinary exchanges: every clock source, both roles, all edges
   // ************************************************************
   sse_row_t rows [8] = '{
      '{sse_pkg::MODE_DIV4, 1'b0, 1'b1, 1'b1, 8'hA5, 8'h3C, 8'h3C, 8'hA5},
      '{sse_pkg::MODE_DIV16, 1'b1, 1'b1, 1'b1, 8'h81, 8'h7E, 8'h7E, 8'h81},
      '{sse_pkg::MODE_DIV64, 1'b0, 1'b0, 1'b1, 8'h01, 8'h80, 8'h80, 8'h01},
      '{sse_pkg::MODE_TMR, 1'b1, 1'b0, 1'b1, 8'hC3, 8'h5A, 8'h5A, 8'hC3},
      '{sse_pkg::MODE_RELOAD, 1'b0, 1'b1, 1'b1, 8'hF0, 8'h0F, 8'h0F, 8'hF0},
      '{sse_pkg::MODE_SLV_SS, 1'b0, 1'b1, 1'b0, 8'h96, 8'h69, 8'h69, 8'h96},
      '{sse_pkg::MODE_SLV_SS, 1'b1, 1'b0, 1'b0, 8'h12, 8'hED, 8'hED, 8'h12},
      '{sse_pkg::MODE_SLV_NOSS, 1'b0, 1'b1, 1'b0, 8'hE7, 8'h18, 8'h18, 8'hE7}};
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic [6:0] stb = 7'h00;
   logic [7:0] wdat = 8'h00;
   logic role_master = 1'b0;
   logic clk_idle_high = 1'b0;
   logic out_before_edge = 1'b1;
   logic [1:0] tick_cnt = 2'h0;
   logic timer_tick = 1'b0;
   logic [7:0] port_control_one, port_status_reg, rate_reload_value, rd_data, rx_data, prx;
   logic transfer_done_flag, tx_ready, rx_valid;
   int fails = 0;
   int tests_run = 0;
   int n;
   sse_link_if link();
   sse_device sse_device_i (.ref_clk(ref_clk), .reset(reset), .link(link),
      .ctl_wr(stb[0]), .ctl_wdata(wdat), .stat_wr(stb[1]), .stat_wdata(wdat),
      .reload_wr(stb[2]), .reload_wdata(wdat), .timer_tick(timer_tick),
      .port_control_one(port_control_one), .port_status_reg(port_status_reg),
      .rate_reload_value(rate_reload_value), .wr_en(stb[3]), .wr_data(wdat),
      .rd_en(stb[4]), .rd_data(rd_data), .transfer_done_flag(transfer_done_flag),
      .flag_clr(stb[5]));
   sse_partner #(.HALF(10'h003), .DEPTH(8)) sse_partner_i (.ref_clk(ref_clk), .reset(reset),
      .link(link), .role_master(role_master), .clk_idle_high(clk_idle_high),
      .out_before_edge(out_before_edge), .tx_valid(stb[6]), .tx_ready(tx_ready),
      .tx_data(wdat), .rx_valid(rx_valid), .rx_data(rx_data));
   sse_chk sse_chk_i (.ref_clk(ref_clk), .reset(reset), .dev_sck_en(link.dev_sck_en),
      .dev_sdo_en(link.dev_sdo_en), .dev_ss_en(link.dev_ss_en), .par_sck_en(link.par_sck_en),
      .par_sdo_en(link.par_sdo_en), .par_ss_en(link.par_ss_en), .sck(link.sck), .ss_n(link.ss_n));
   initial
      forever #12.5 ref_clk = ~ref_clk;
   always @(negedge ref_clk)
   begin
      tick_cnt <= tick_cnt + 2'h1;
      timer_tick <= (tick_cnt == 2'h3);
   end
   // ************************************************************
   // tasks
   // ************************************************************
   // one strobe: 0 ctl, 1 stat, 2 reload, 3 write, 4 read, 5 flag clear, 6 partner push
   task automatic strobe(input int k, input logic [7:0] d);
      @(negedge ref_clk);
      wdat = d;
      stb[k] = 1'b1;
      @(negedge ref_clk);
      stb = 7'h00;
   endtask
   // both ends go quiet first so no clock level moves while configured
   task automatic setup(input sse_row_t w);
      role_master = 1'b0;
      strobe(0, 8'h00);
      repeat (2) @(negedge ref_clk);
      role_master = !w.dev_master;
      clk_idle_high = w.ckp;
      out_before_edge = w.cke;
      strobe(1, {1'b0, w.cke, 6'h00});
      strobe(2, 8'h02);
      strobe(0, {2'b00, 1'b1, w.ckp, w.mode});
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic xfer_wait();
      logic got;
      got = 1'b0;
      for (int i = 0; i < 3000; i++)
      begin
         @(negedge ref_clk);
         if (rx_valid === 1'b1)
         begin
            prx = rx_data;
            got = 1'b1;
         end
         if (got && transfer_done_flag === 1'b1 && link.ss_n === 1'b1 && port_status_reg[1] === 1'b0)
            return;
      end
      $display("ERROR byte wait expected done seen timeout");
      fails++;
      close_out();
   endtask
   // ************************************************************
   // main sequence
   // ************************************************************
   initial
   begin
      repeat (2) @(negedge ref_clk);
      reset = 1'b0;
      foreach (rows[r])
      begin
         setup(rows[r]);
         if (rows[r].dev_master)
         begin
            strobe(6, rows[r].par_byte);
            strobe(3, rows[r].dev_byte);
         end
         else
         begin
            strobe(3, rows[r].dev_byte);
            strobe(6, rows[r].par_byte);
         end
         xfer_wait();
         `CHK("device rx", rows[r].exp_dev, rd_data)
         `CHK("partner rx", rows[r].exp_par, prx)
         `CHK("full flag", 1'b1, port_status_reg[0])
         strobe(4, 8'h00);
         strobe(5, 8'h00);
         `CHK("flags cleared", 2'b00, {port_status_reg[0], transfer_done_flag})
         $display("row %0d done", r);
      end
      // fill the partner queue until it refuses, then drain with stalls
      setup(rows[0]);
      n = 0;
      for (int i = 0; i < 12 && tx_ready === 1'b1; i++)
      begin
         strobe(6, 8'(8'h10 + i));
         n++;
      end
      `CHK("queue depth", 8, n)
      for (int k = 0; k < 9; k++)
      begin
         strobe(3, 8'(k));
         xfer_wait();
         `CHK("queued byte", (k < 8) ? 8'(8'h10 + k) : 8'hFF, rd_data)
         `CHK("partner rx", 8'(k), prx)
         strobe(4, 8'h00);
         strobe(5, 8'h00);
         repeat (5) @(negedge ref_clk);
      end
      $display("queue test done");
      // write while busy is dropped and latches the collision flag
      setup(rows[2]);
      strobe(3, 8'h3C);
      strobe(3, 8'hC3);
      `CHK("collision flag", 1'b1, port_control_one[7])
      xfer_wait();
      `CHK("first byte kept", 8'h3C, prx)
      strobe(5, 8'h00);
      strobe(3, 8'h77);
      repeat (4) @(negedge ref_clk);
      `CHK("write blocked", 2'b01, {port_status_reg[1], link.ss_n})
      strobe(0, {4'h2, sse_pkg::MODE_DIV64});
      `CHK("collision cleared", 1'b0, port_control_one[7])
      strobe(3, 8'h77);
      xfer_wait();
      `CHK("write after clear", 8'h77, prx)
      $display("collision test done");
      // disabled module ignores writes and leaves its data line alone
      strobe(0, 8'h00);
      strobe(3, 8'h5A);
      repeat (4) @(negedge ref_clk);
      `CHK("disabled", 4'b0010, {port_control_one[7], port_status_reg[1], link.ss_n,
         link.dev_sdo_en})
      strobe(4, 8'h00);
      strobe(1, 8'hFF);
      `CHK("status write", 8'hC0, port_status_reg)
      strobe(0, 8'hCF);
      `CHK("control write", 8'hCF, port_control_one)
      strobe(2, 8'hA5);
      `CHK("reload write", 8'hA5, rate_reload_value)
      $display("register test done");
      reset = 1'b1;
      repeat (2) @(negedge ref_clk);
      reset = 1'b0;
      `CHK("reset regs", 24'h000000, {port_control_one, port_status_reg, rate_reload_value})
      `CHK("reset link", 4'b0100, {transfer_done_flag, link.ss_n, link.sck, link.dev_sdo_en})
      $display("reset test done");
      close_out();
   end
endmodule
